// *** hw/sensor_readout_config_regs.sv ***
// Purpose: Readout configuration registers and the settings derived from them.
// Assumes: Window MSBs and scan rows come from neighbouring logic on i_mclk.
// Notes: Registers written and read through the two-wire serial slave.
`timescale 1ns/1ns
module sensor_readout_config_regs (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // Two-wire serial pins
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   // Window MSBs and scan rows from neighbouring logic
   input wire logic [8:0] i_scan_start_row,
   input wire logic [8:0] i_scan_end_row,
   input wire logic [7:0] i_disp_start_row_high,
   input wire logic [7:0] i_disp_end_row_high,
   input wire logic [7:0] i_disp_start_col_high,
   input wire logic [7:0] i_disp_end_col_high,
   // Window addresses
   output logic [9:0] o_scan_start_row,
   output logic [9:0] o_scan_end_row,
   output logic [8:0] o_disp_start_row,
   output logic [8:0] o_disp_end_row,
   output logic [9:0] o_disp_start_col,
   output logic [9:0] o_disp_end_col,
   // Timing settings
   output logic [11:0] o_integration_rows,
   output logic [10:0] o_line_gap,
   output logic [11:0] o_frame_gap,
   // Gain settings
   output logic [5:0] o_global_gain_code,
   output logic [11:0] o_global_gain_db_q8,
   output logic [10:0] o_red_gain_q8,
   output logic [10:0] o_green_gain_q8,
   output logic [10:0] o_blue_gain_q8,
   // Response curve
   output logic [13:0] o_knee1_slope,
   output logic o_knee1_enable,
   output logic [7:0] o_knee1_level_a
);
   import sensor_cfg_pkg::*;

   logic [7:0] regs [REG_COUNT];
   logic [7:0] next_regs [REG_COUNT];
   reg_write_t wr;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   logic [7:0] win;
   logic [11:0] next_integration_rows, next_frame_gap;
   logic [10:0] next_line_gap;
   logic [13:0] next_knee1_slope;
   logic next_knee1_enable;
   logic [7:0] next_knee1_level_a;
   logic [9:0] next_scan_start_row, next_scan_end_row, next_disp_start_col, next_disp_end_col;
   logic [8:0] next_disp_start_row, next_disp_end_row;
   logic [5:0] next_global_gain_code;
   logic [11:0] next_global_gain_db_q8;
   logic [10:0] next_red_gain_q8, next_green_gain_q8, next_blue_gain_q8;

   // Offset in range of the bank
   function automatic logic reg_hit(input logic [7:0] addr);
      reg_hit = (addr >= OFS_WINDOW_LOW_BITS) && (addr <= OFS_KNEE1_LEVEL_A);
   endfunction : reg_hit

   // Array slot of an offset
   function automatic int reg_slot(input logic [7:0] addr);
      reg_slot = int'(addr - OFS_WINDOW_LOW_BITS);
   endfunction : reg_slot

   // Writable bits per slot
   function automatic logic [7:0] reg_mask(input int slot);
      logic [7:0] ofs;
      ofs = OFS_WINDOW_LOW_BITS + 8'(slot);
      case (ofs)
         OFS_WINDOW_LOW_BITS: reg_mask = MASK_WINDOW_LOW_BITS;
         OFS_INTEGRATION_TIME_HIGH, OFS_FRAME_GAP_HIGH: reg_mask = MASK_NIBBLE_HIGH;
         OFS_LINE_GAP_HIGH: reg_mask = MASK_LINE_GAP_HIGH;
         OFS_KNEE1_SLOPE_HIGH: reg_mask = MASK_KNEE1_SLOPE_HIGH;
         default: reg_mask = MASK_FULL;
      endcase
   endfunction : reg_mask

   // Linear colour gain: 1.0 at code 0 up to the 14 dB factor at 7F
   function automatic logic [10:0] colour_q8(input logic [7:0] code);
      int c;
      c = (code > COLOUR_CODE_MAX) ? int'(COLOUR_CODE_MAX) : int'(code);
      colour_q8 = 11'(Q8_ONE + (c * (COLOUR_Q8_MAX - Q8_ONE)) / int'(COLOUR_CODE_MAX));
   endfunction : colour_q8

   serial_cfg_slave u_serial (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_scl(i_scl),
      .i_sda(i_sda),
      .o_sda(o_sda),
      .o_sda_oe(o_sda_oe),
      .o_wr(wr),
      .o_rd_addr(rd_addr),
      .i_rd_data(rd_data)
   );

   // One storage slot per register, masked so reserved bits never hold ones
   for (genvar g = 0; g < REG_COUNT; g++) begin : g_reg
      always_comb begin
         next_regs[g] = regs[g];
         if (wr.strobe && reg_hit(wr.addr) && (reg_slot(wr.addr) == g)) begin
            next_regs[g] = wr.data & reg_mask(g);
         end
      end

      // Window bits reset to their fixed pattern, the rest to zero
      always_ff @(posedge i_mclk or negedge i_nrst) begin
         if (!i_nrst) begin
            regs[g] <= (g == 0) ? RST_WINDOW_LOW_BITS : RST_OTHER;
         end else begin
            regs[g] <= next_regs[g];
         end
      end
   end

   // Read mux; unmapped offsets answer zero
   always_comb begin
      rd_data = 8'h00;
      if (reg_hit(rd_addr)) begin
         rd_data = regs[reg_slot(rd_addr)];
      end
   end

   // Derived settings
   always_comb begin
      win = regs[reg_slot(OFS_WINDOW_LOW_BITS)];
      // Raise scan rows by one only when asked; width grows so 1FF+1 stays exact
      if (win[POS_SCAN_ROW_OFFSET]) begin
         next_scan_start_row = {1'b0, i_scan_start_row} + 10'h001;
         next_scan_end_row = {1'b0, i_scan_end_row} + 10'h001;
      end else begin
         next_scan_start_row = {1'b0, i_scan_start_row};
         next_scan_end_row = {1'b0, i_scan_end_row};
      end
      next_disp_start_row = {i_disp_start_row_high, win[POS_START_ROW]};
      next_disp_end_row = {i_disp_end_row_high, win[POS_END_ROW]};
      next_disp_start_col = {i_disp_start_col_high, win[POS_START_COL_HI], win[POS_START_COL_LO]};
      next_disp_end_col = {i_disp_end_col_high, win[POS_END_COL_HI], win[POS_END_COL_LO]};
      next_integration_rows = {regs[reg_slot(OFS_INTEGRATION_TIME_HIGH)][3:0],
                               regs[reg_slot(OFS_INTEGRATION_TIME_LOW)]};
      next_line_gap = {regs[reg_slot(OFS_LINE_GAP_HIGH)][2:0], regs[reg_slot(OFS_LINE_GAP_LOW)]};
      next_frame_gap = {regs[reg_slot(OFS_FRAME_GAP_HIGH)][3:0], regs[reg_slot(OFS_FRAME_GAP_LOW)]};
      next_knee1_slope = {regs[reg_slot(OFS_KNEE1_SLOPE_HIGH)][5:0], regs[reg_slot(OFS_KNEE1_SLOPE_LOW)]};
      // Knee applies only while some slope bit is set
      next_knee1_enable = (next_knee1_slope != 14'h0000);
      next_knee1_level_a = regs[reg_slot(OFS_KNEE1_LEVEL_A)];
      // Codes past the top of the range saturate rather than wrap
      if (regs[reg_slot(OFS_GLOBAL_VIDEO_GAIN)] > GLOBAL_CODE_MAX) begin
         next_global_gain_code = GLOBAL_CODE_MAX[5:0];
      end else begin
         next_global_gain_code = regs[reg_slot(OFS_GLOBAL_VIDEO_GAIN)][5:0];
      end
      // Equal dB per step, so dB is linear in the code
      next_global_gain_db_q8 = 12'((int'(next_global_gain_code) * GLOBAL_DB_MAX * Q8_ONE)
                                   / int'(GLOBAL_CODE_MAX));
      next_red_gain_q8 = colour_q8(regs[reg_slot(OFS_RED_CHANNEL_GAIN)]);
      next_green_gain_q8 = colour_q8(regs[reg_slot(OFS_GREEN_CHANNEL_GAIN)]);
      next_blue_gain_q8 = colour_q8(regs[reg_slot(OFS_BLUE_CHANNEL_GAIN)]);
   end

   // Outputs registered so neighbours see glitch-free settings
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_scan_start_row <= 10'h000;
         o_scan_end_row <= 10'h000;
         o_disp_start_row <= 9'h000;
         o_disp_end_row <= 9'h000;
         o_disp_start_col <= 10'h000;
         o_disp_end_col <= 10'h000;
         o_integration_rows <= 12'h000;
         o_line_gap <= 11'h000;
         o_frame_gap <= 12'h000;
         o_global_gain_code <= 6'h00;
         o_global_gain_db_q8 <= 12'h000;
         o_red_gain_q8 <= 11'h100;
         o_green_gain_q8 <= 11'h100;
         o_blue_gain_q8 <= 11'h100;
         o_knee1_slope <= 14'h0000;
         o_knee1_enable <= 1'b0;
         o_knee1_level_a <= 8'h00;
      end else begin
         o_scan_start_row <= next_scan_start_row;
         o_scan_end_row <= next_scan_end_row;
         o_disp_start_row <= next_disp_start_row;
         o_disp_end_row <= next_disp_end_row;
         o_disp_start_col <= next_disp_start_col;
         o_disp_end_col <= next_disp_end_col;
         o_integration_rows <= next_integration_rows;
         o_line_gap <= next_line_gap;
         o_frame_gap <= next_frame_gap;
         o_global_gain_code <= next_global_gain_code;
         o_global_gain_db_q8 <= next_global_gain_db_q8;
         o_red_gain_q8 <= next_red_gain_q8;
         o_green_gain_q8 <= next_green_gain_q8;
         o_blue_gain_q8 <= next_blue_gain_q8;
         o_knee1_slope <= next_knee1_slope;
         o_knee1_enable <= next_knee1_enable;
         o_knee1_level_a <= next_knee1_level_a;
      end
   end

endmodule : sensor_readout_config_regs

// *** hw/sensor_cfg_pkg.sv ***
// Purpose: Shared constants and types for the readout configuration register bank.
// Assumes: Byte-wide registers reached through a two-wire serial slave.
// Notes: Every offset, mask, reset value and field position lives here.
package sensor_cfg_pkg;

   // Serial slave address, arbitrary value
   localparam logic [6:0] SLAVE_ADDR = 7'h2A;

   // Register offsets
   localparam logic [7:0] OFS_WINDOW_LOW_BITS = 8'h12;
   localparam logic [7:0] OFS_INTEGRATION_TIME_HIGH = 8'h13;
   localparam logic [7:0] OFS_INTEGRATION_TIME_LOW = 8'h14;
   localparam logic [7:0] OFS_LINE_GAP_HIGH = 8'h15;
   localparam logic [7:0] OFS_LINE_GAP_LOW = 8'h16;
   localparam logic [7:0] OFS_FRAME_GAP_HIGH = 8'h17;
   localparam logic [7:0] OFS_FRAME_GAP_LOW = 8'h18;
   localparam logic [7:0] OFS_GLOBAL_VIDEO_GAIN = 8'h19;
   localparam logic [7:0] OFS_BLUE_CHANNEL_GAIN = 8'h1A;
   localparam logic [7:0] OFS_GREEN_CHANNEL_GAIN = 8'h1B;
   localparam logic [7:0] OFS_RED_CHANNEL_GAIN = 8'h1C;
   localparam logic [7:0] OFS_KNEE1_SLOPE_HIGH = 8'h1D;
   localparam logic [7:0] OFS_KNEE1_SLOPE_LOW = 8'h1E;
   localparam logic [7:0] OFS_KNEE1_LEVEL_A = 8'h1F;
   localparam int REG_COUNT = 14;

   // Reset values; every register but the window one clears
   localparam logic [7:0] RST_WINDOW_LOW_BITS = 8'h32;
   localparam logic [7:0] RST_OTHER = 8'h00;

   // Writable bit masks; reserved bits stay zero
   localparam logic [7:0] MASK_WINDOW_LOW_BITS = 8'h7F;
   localparam logic [7:0] MASK_NIBBLE_HIGH = 8'h0F;
   localparam logic [7:0] MASK_LINE_GAP_HIGH = 8'h07;
   localparam logic [7:0] MASK_KNEE1_SLOPE_HIGH = 8'h3F;
   localparam logic [7:0] MASK_FULL = 8'hFF;

   // Field positions in the window low bits register
   localparam int POS_SCAN_ROW_OFFSET = 6;
   localparam int POS_END_COL_HI = 5;
   localparam int POS_END_COL_LO = 4;
   localparam int POS_START_COL_HI = 3;
   localparam int POS_START_COL_LO = 2;
   localparam int POS_END_ROW = 1;
   localparam int POS_START_ROW = 0;

   // Gain code limits and scaling
   localparam logic [7:0] GLOBAL_CODE_MAX = 8'h3F;
   localparam logic [7:0] COLOUR_CODE_MAX = 8'h7F;
   localparam int GLOBAL_DB_MAX = 15;
   localparam int COLOUR_DB_MAX = 14;
   localparam int Q8_ONE = 256;
   localparam int COLOUR_Q8_MAX = 1283;    // 14 dB as a linear factor, times 256

   // One register write from the serial slave
   typedef struct packed {
      logic strobe;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_write_t;

   // Serial slave byte states
   typedef enum logic [2:0] {
      SER_IDLE, SER_ADDR, SER_ACK_ADDR, SER_WRITE, SER_ACK_WRITE, SER_READ, SER_ACK_READ
   } ser_state_t;

endpackage : sensor_cfg_pkg

// *** hw/serial_cfg_slave.sv ***
// Purpose: Two-wire serial slave that carries register writes and reads.
// Assumes: Bus clock far below i_mclk; first written byte sets the register pointer.
// Notes: Pointer increments with each data byte written or read, so bursts walk the register map.
`timescale 1ns/1ns
module serial_cfg_slave (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // Two-wire pins
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   // Register side
   output sensor_cfg_pkg::reg_write_t o_wr,
   output logic [7:0] o_rd_addr,
   input wire logic [7:0] i_rd_data
);
   import sensor_cfg_pkg::*;

   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic scl_prev;
   logic sda_prev;
   ser_state_t state, next_state;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [7:0] shift, next_shift;
   logic [7:0] ptr, next_ptr;
   logic have_ptr, next_have_ptr;
   logic is_read, next_is_read;
   logic sda_oe, next_sda_oe;
   reg_write_t wr, next_wr;
   logic scl_rise, scl_fall, start_seen, stop_seen;

   // Pin levels seen only after the second stage
   assign scl_rise = scl_sync[1] & ~scl_prev;
   assign scl_fall = ~scl_sync[1] & scl_prev;
   assign start_seen = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
   assign stop_seen = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];

   // Byte engine
   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shift = shift;
      next_ptr = ptr;
      next_have_ptr = have_ptr;
      next_is_read = is_read;
      next_sda_oe = sda_oe;
      next_wr = '{strobe: 1'b0, addr: ptr, data: shift};
      if (start_seen) begin
         next_state = SER_ADDR;
         next_bit_cnt = 4'h0;
         next_have_ptr = 1'b0;
         next_sda_oe = 1'b0;
      end else if (stop_seen) begin
         next_state = SER_IDLE;
         next_sda_oe = 1'b0;
      end else if (scl_rise) begin
         case (state)
            SER_ADDR, SER_WRITE: begin
               next_shift = {shift[6:0], sda_sync[1]};
               next_bit_cnt = bit_cnt + 4'h1;
            end
            SER_ACK_READ: begin
               // A not-acknowledge ends the read burst
               if (sda_sync[1]) begin
                  next_state = SER_IDLE;
               end
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (state)
            SER_ADDR: begin
               if (bit_cnt == 4'h8) begin
                  if (shift[7:1] == SLAVE_ADDR) begin
                     next_state = SER_ACK_ADDR;
                     next_is_read = shift[0];
                     next_sda_oe = 1'b1;
                  end else begin
                     next_state = SER_IDLE;
                  end
               end
            end
            SER_WRITE: begin
               if (bit_cnt == 4'h8) begin
                  next_state = SER_ACK_WRITE;
                  next_sda_oe = 1'b1;
                  if (!have_ptr) begin
                     next_ptr = shift;
                     next_have_ptr = 1'b1;
                  end else begin
                     next_wr = '{strobe: 1'b1, addr: ptr, data: shift};
                     next_ptr = ptr + 8'h01;
                  end
               end
            end
            SER_ACK_WRITE: begin
               next_state = SER_WRITE;
               next_sda_oe = 1'b0;
               next_bit_cnt = 4'h0;
            end
            SER_ACK_ADDR, SER_ACK_READ: begin
               if (is_read) begin
                  // Load next byte and drive its MSB
                  next_state = SER_READ;
                  next_shift = i_rd_data;
                  next_sda_oe = ~i_rd_data[7];
                  next_ptr = ptr + 8'h01;
                  next_bit_cnt = 4'h1;
               end else begin
                  next_state = SER_WRITE;
                  next_sda_oe = 1'b0;
                  next_bit_cnt = 4'h0;
               end
            end
            SER_READ: begin
               if (bit_cnt == 4'h8) begin
                  next_state = SER_ACK_READ;
                  next_sda_oe = 1'b0;
               end else begin
                  next_shift = {shift[6:0], 1'b0};
                  next_sda_oe = ~shift[6];
                  next_bit_cnt = bit_cnt + 4'h1;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Synchronisers and engine state
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
         state <= SER_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         ptr <= 8'h00;
         have_ptr <= 1'b0;
         is_read <= 1'b0;
         sda_oe <= 1'b0;
         wr <= '0;
      end else begin
         scl_sync <= {scl_sync[0], i_scl};
         sda_sync <= {sda_sync[0], i_sda};
         scl_prev <= scl_sync[1];
         sda_prev <= sda_sync[1];
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shift <= next_shift;
         ptr <= next_ptr;
         have_ptr <= next_have_ptr;
         is_read <= next_is_read;
         sda_oe <= next_sda_oe;
         wr <= next_wr;
      end
   end

   // Open drain: only ever pulls low
   assign o_sda = 1'b0;
   assign o_sda_oe = sda_oe;
   assign o_wr = wr;
   assign o_rd_addr = ptr;

endmodule : serial_cfg_slave

// *** bench/sensor_cfg_sva.sv ***
// Purpose: Port-level checks for the readout configuration registers.
// Assumes: Single i_mclk domain, outputs registered one clock after their cause.
// Notes: Register contents are hidden, so checks tie outputs to inputs and to each other.
`timescale 1ns/1ns
module sensor_cfg_checker (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // Neighbour inputs
   input wire logic [8:0] i_scan_start_row,
   input wire logic [8:0] i_scan_end_row,
   input wire logic [7:0] i_disp_start_row_high,
   input wire logic [7:0] i_disp_end_row_high,
   input wire logic [7:0] i_disp_start_col_high,
   input wire logic [7:0] i_disp_end_col_high,
   // Watched outputs
   input wire logic [9:0] o_scan_start_row,
   input wire logic [9:0] o_scan_end_row,
   input wire logic [8:0] o_disp_start_row,
   input wire logic [8:0] o_disp_end_row,
   input wire logic [9:0] o_disp_start_col,
   input wire logic [9:0] o_disp_end_col,
   input wire logic [5:0] o_global_gain_code,
   input wire logic [11:0] o_global_gain_db_q8,
   input wire logic [10:0] o_red_gain_q8,
   input wire logic [10:0] o_green_gain_q8,
   input wire logic [10:0] o_blue_gain_q8,
   input wire logic [13:0] o_knee1_slope,
   input wire logic o_knee1_enable
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);

   // Both scan rows share one offset bit, so they must step together
   a_scan_same_step: assert property ($past(i_nrst) |->
      (o_scan_start_row - {1'b0, $past(i_scan_start_row)}) == (o_scan_end_row - {1'b0, $past(i_scan_end_row)}))
      else $error("scan rows stepped by different amounts");
   a_scan_step_max: assert property ($past(i_nrst) |->
      (o_scan_start_row - {1'b0, $past(i_scan_start_row)}) <= 10'h001)
      else $error("scan start row step is not zero or one");
   a_disp_row_msb: assert property ($past(i_nrst) |->
      o_disp_start_row[8:1] == $past(i_disp_start_row_high) && o_disp_end_row[8:1] == $past(i_disp_end_row_high))
      else $error("display row MSBs not taken from inputs");
   a_disp_col_msb: assert property ($past(i_nrst) |->
      o_disp_start_col[9:2] == $past(i_disp_start_col_high) && o_disp_end_col[9:2] == $past(i_disp_end_col_high))
      else $error("display column MSBs not taken from inputs");
   // No write can land this soon after release, so reset LSBs must show
   a_window_lsb_reset: assert property ($rose(i_nrst) |-> ##1
      o_disp_end_col[1:0] == 2'b11 && o_disp_start_col[1:0] == 2'b00
      && o_disp_end_row[0] == 1'b1 && o_disp_start_row[0] == 1'b0)
      else $error("window low bits wrong after reset");
   // Settled slope decides whether the knee applies
   a_knee_off_zero: assert property ($stable(o_knee1_slope) ##1 $stable(o_knee1_slope) |->
      o_knee1_enable == (o_knee1_slope != 14'h0000))
      else $error("knee enable disagrees with slope");
   a_global_db_map: assert property ($stable(o_global_gain_code) ##1 $stable(o_global_gain_code) |->
      o_global_gain_db_q8 == 12'(o_global_gain_code * 15 * 256 / 63))
      else $error("global gain dB does not match code");
   a_red_range: assert property (o_red_gain_q8 >= 11'h100 && o_red_gain_q8 <= 11'h503)
      else $error("red gain outside 0 to 14 dB");
   a_green_blue_range: assert property (o_green_gain_q8 >= 11'h100 && o_green_gain_q8 <= 11'h503
      && o_blue_gain_q8 >= 11'h100 && o_blue_gain_q8 <= 11'h503)
      else $error("green or blue gain outside 0 to 14 dB");
endmodule : sensor_cfg_checker

bind sensor_readout_config_regs sensor_cfg_checker i_chk (.*);

// *** bench/tb_top.sv ***
// Purpose: Self-checking bench for the readout configuration registers.
// Assumes: Bench bit-bangs the two-wire bus with 6-clock phases.
// Notes: Reads are checked by a monitor against a queue of expected bytes.
`timescale 1ns/1ns
module tb_top;
   import sensor_cfg_pkg::*;
   logic i_mclk = 1'b0;
   logic i_nrst = 1'b0;
   logic i_scl = 1'b1;
   logic sda_m = 1'b1;
   logic i_sda;
   logic [8:0] i_scan_start_row = 9'h000, i_scan_end_row = 9'h000;
   logic [7:0] i_disp_start_row_high = 8'h00, i_disp_end_row_high = 8'h00;
   logic [7:0] i_disp_start_col_high = 8'h00, i_disp_end_col_high = 8'h00;
   logic o_sda, o_sda_oe, o_knee1_enable;
   logic [9:0] o_scan_start_row, o_scan_end_row, o_disp_start_col, o_disp_end_col;
   logic [8:0] o_disp_start_row, o_disp_end_row;
   logic [11:0] o_integration_rows, o_frame_gap, o_global_gain_db_q8;
   logic [10:0] o_line_gap, o_red_gain_q8, o_green_gain_q8, o_blue_gain_q8;
   logic [13:0] o_knee1_slope;
   logic [5:0] o_global_gain_code;
   logic [7:0] o_knee1_level_a, rd_val;
   logic [7:0] m [8'h12:8'h1F];
   logic [15:0] exp_q [$];
   logic [15:0] bt [7] = '{16'h193F, 16'h1C7F, 16'h1B00, 16'h1AFF, 16'h1D00, 16'h1E00, 16'h12F0};
   int num_errors = 0, n_tests = 0, cycles = 0;
   event rd_seen;

   // Open-drain wire: pulled up unless someone pulls low
   assign i_sda = (o_sda_oe ? o_sda : 1'b1) & sda_m;
   always #25 i_mclk = ~i_mclk;

   sensor_readout_config_regs i_dut (.*);

   task automatic end_sim();
      $display("Checks %0d, errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Hang guard, sized well above the full sequence
   always @(posedge i_mclk) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         num_errors++;
         end_sim();
      end
   end

   // Every byte read back is paired with the oldest expectation
   always @(rd_seen) chk("read_data", exp_q.pop_front(), {8'h00, rd_val});

   function automatic logic [7:0] mask(input logic [7:0] o);
      case (o)
         8'h12: return 8'h7F;
         8'h13, 8'h17: return 8'h0F;
         8'h15: return 8'h07;
         8'h1D: return 8'h3F;
         default: return 8'hFF;
      endcase
   endfunction : mask

   function automatic logic [15:0] col(input logic [7:0] c);
      logic [7:0] s;
      s = (c > 8'h7F) ? 8'h7F : c;
      return 16'(256 + s * 1027 / 127);
   endfunction : col

   task automatic model_reset();
      foreach (m[i]) m[i] = 8'h00;
      m[8'h12] = 8'h32;
   endtask : model_reset

   task automatic half();
      repeat (6) @(posedge i_mclk);
   endtask : half

   // One SCL pulse; data set mid-low, sampled at the end of high
   task automatic bit_io(input logic b, output logic r);
      i_scl <= 1'b0;
      half();
      sda_m <= b;
      half();
      i_scl <= 1'b1;
      half();
      r = i_sda;
   endtask : bit_io

   task automatic cond(input logic first, input logic second);
      i_scl <= 1'b0;
      half();
      sda_m <= first;
      half();
      i_scl <= 1'b1;
      half();
      sda_m <= second;
      half();
   endtask : cond

   task automatic wbyte(input logic [7:0] v, input logic nack_exp);
      logic a;
      for (int i = 7; i >= 0; i--) bit_io(v[i], a);
      bit_io(1'b1, a);
      chk("ack", {15'h0000, nack_exp}, {15'h0000, a});
   endtask : wbyte

   task automatic wr(input logic [7:0] o, input logic [7:0] v);
      cond(1'b1, 1'b0);
      wbyte({SLAVE_ADDR, 1'b0}, 1'b0);
      wbyte(o, 1'b0);
      wbyte(v, 1'b0);
      cond(1'b0, 1'b1);
      if (o >= 8'h12 && o <= 8'h1F) m[o] = v & mask(o);
   endtask : wr

   task automatic rd(input logic [7:0] o, input int n);
      logic a;
      logic [7:0] v;
      cond(1'b1, 1'b0);
      wbyte({SLAVE_ADDR, 1'b0}, 1'b0);
      wbyte(o, 1'b0);
      cond(1'b1, 1'b0);
      wbyte({SLAVE_ADDR, 1'b1}, 1'b0);
      for (int k = 0; k < n; k++) begin
         exp_q.push_back((o >= 8'h12 && o <= 8'h1F) ? {8'h00, m[o]} : 16'h0000);
         for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
         bit_io(k == n - 1, a);
         rd_val = v;
         ->rd_seen;
         o++;
      end
      cond(1'b0, 1'b1);
   endtask : rd

   // Fresh neighbour inputs, then every derived output against the model
   task automatic check_all();
      logic [7:0] w;
      logic [7:0] g;
      @(posedge i_mclk);
      {i_scan_start_row, i_scan_end_row, i_disp_start_row_high, i_disp_end_row_high, i_disp_start_col_high,
         i_disp_end_col_high} <= 50'({$urandom(), $urandom()});
      repeat (3) @(posedge i_mclk);
      w = m[8'h12];
      g = (m[8'h19] > 8'h3F) ? 8'h3F : m[8'h19];
      chk("scan_start", {1'b0, i_scan_start_row} + w[6], o_scan_start_row);
      chk("scan_end", {1'b0, i_scan_end_row} + w[6], o_scan_end_row);
      chk("disp_end_col", {i_disp_end_col_high, w[5:4]}, o_disp_end_col);
      chk("disp_start_col", {i_disp_start_col_high, w[3:2]}, o_disp_start_col);
      chk("disp_end_row", {i_disp_end_row_high, w[1]}, o_disp_end_row);
      chk("disp_start_row", {i_disp_start_row_high, w[0]}, o_disp_start_row);
      chk("integration", {m[8'h13][3:0], m[8'h14]}, o_integration_rows);
      chk("line_gap", {m[8'h15][2:0], m[8'h16]}, o_line_gap);
      chk("frame_gap", {m[8'h17][3:0], m[8'h18]}, o_frame_gap);
      chk("global_code", g, o_global_gain_code);
      chk("global_db", 16'(g * 15 * 256 / 63), o_global_gain_db_q8);
      chk("red_gain", col(m[8'h1C]), o_red_gain_q8);
      chk("green_gain", col(m[8'h1B]), o_green_gain_q8);
      chk("blue_gain", col(m[8'h1A]), o_blue_gain_q8);
      chk("knee_slope", {m[8'h1D][5:0], m[8'h1E]}, o_knee1_slope);
      chk("knee_enable", {m[8'h1D][5:0], m[8'h1E]} != 14'h0000, o_knee1_enable);
      chk("knee_level", m[8'h1F], o_knee1_level_a);
   endtask : check_all

   initial begin
      void'($urandom(15));
      model_reset();
      repeat (6) @(posedge i_mclk);
      i_nrst <= 1'b1;
      repeat (4) @(posedge i_mclk);
      // Reset values, read as one auto-incrementing burst
      check_all();
      rd(8'h12, 14);
      // Offset bit and reserved bit 7 both set
      wr(8'h12, 8'hC0 | 8'($urandom()));
      check_all();
      for (int o = 8'h13; o <= 8'h1F; o++) wr(8'(o), 8'($urandom()));
      rd(8'h12, 14);
      check_all();
      // Gain limits, saturation and zero slope
      foreach (bt[i]) wr(bt[i][15:8], bt[i][7:0]);
      check_all();
      wr(8'h1E, 8'h01);
      wr(8'h19, 8'hFF);
      check_all();
      // Unmapped offset and a foreign slave address
      wr(8'h30, 8'h5A);
      rd(8'h30, 1);
      cond(1'b1, 1'b0);
      wbyte({SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1);
      cond(1'b0, 1'b1);
      // Second reset in mid-run must restore defaults
      i_nrst <= 1'b0;
      repeat (2) @(posedge i_mclk);
      i_nrst <= 1'b1;
      model_reset();
      repeat (3) @(posedge i_mclk);
      check_all();
      rd(8'h12, 2);
      end_sim();
   end
endmodule : tb_top
